// ---- bench/stap_jtag_ctl.sv ----
// Purpose: board test controller model driving the serial port
// Assumes: test clock runs only inside frames, period 125 ns
// Notes: after a scan tms and tdi fall back to their pull-up level; after home tms stays low, after step it keeps the ms value given
module stap_jtag_ctl (
    output logic tck_o, // test clock
    output logic tms_o, // mode select
    output logic tdi_o, // serial data to port
    input wire logic tdo_i, // serial data from port
    input wire logic tdo_oe_i // port drives tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // pins change mid-low so they are settled at the rise
    task automatic step(input logic ms, input logic di, output logic so);
        tms_o = ms;
        tdi_o = di;
        #31.2 tck_o = 1'b1;
        // a released line has no pull, so show the inverse of the last bit
        so = tdo_oe_i ? tdo_i : ~tdo_i;
        #62.5 tck_o = 1'b0;
        #31.3;
    endtask : step
    task automatic home();
        logic so;
        repeat (5) step(1'b1, 1'b1, so);
        step(1'b0, 1'b1, so);
    endtask : home
    // idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input logic [127:0] din,
                        input int n, output logic [127:0] dout);
        logic so;
        dout = '0;
        step(1'b1, 1'b1, so);
        if (ir) step(1'b1, 1'b1, so);
        step(1'b0, 1'b1, so);
        step(1'b0, 1'b1, so);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], so);
            dout[i] = so;
        end
        step(1'b1, 1'b1, so);
        step(1'b0, 1'b1, so);
        tms_o = 1'b1;
        tdi_o = 1'b1;
    endtask : scan
endmodule : stap_jtag_ctl

// ---- bench/stap_tap_properties.sv ----
// Purpose: sequencing and edge checks on the test port pins
// Assumes: tms and tdi change only while tck is low
// Notes: tck checks sample on falling edges, where outputs have settled
module stap_tap_checker
    import stap_pkg::*;
#(
    parameter int BSR_W = STAP_BSR_W
) (
    input wire logic sys_clk_i, // memory clock
    input wire logic rst_i, // reset
    input wire logic clk_en_i, // sys enable
    input wire logic [BSR_W-1:0] ring_i, // pin ring
    input wire logic tck_i, // test clock
    input wire logic tms_i, // mode select
    input wire logic tdi_i, // serial in
    input wire logic tdo_o, // serial out
    input wire logic tdo_oe_o, // out enable
    input wire logic outputs_hiz_o, // float memory
    input wire logic [3:0] state_o // controller state
);
    timeunit 1ns;
    timeprecision 100ps;
    property p_reset5;
        @(negedge tck_i) disable iff (rst_i)
        tms_i [*5] |=> state_o == ST_RESET;
    endproperty
    a_reset5: assert property (p_reset5) else $error("no reset");
    property p_oe;
        @(negedge tck_i) disable iff (rst_i)
        tdo_oe_o == (state_o == ST_SH_DR || state_o == ST_SH_IR);
    endproperty
    a_oe: assert property (p_oe) else $error("bad tdo enable");
    // a change seen while tck is high came from the wrong edge
    property p_tdo_fall;
        @(posedge sys_clk_i) disable iff (rst_i)
        $changed({tdo_o, tdo_oe_o}) |-> !tck_i;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved");
    property p_cap_ir;
        @(negedge tck_i) disable iff (rst_i)
        (state_o == ST_SH_IR && $past(state_o) == ST_CAP_IR) |->
        tdo_o ##1 (state_o != ST_SH_IR || !tdo_o);
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("bad ir cap");
    property p_idle;
        @(negedge tck_i) disable iff (rst_i)
        (state_o == ST_IDLE && !tms_i) |=> state_o == ST_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("left idle");
    property p_run;
        @(negedge tck_i) disable iff (rst_i)
        (state_o == ST_RESET && !tms_i) |=> state_o == ST_IDLE;
    endproperty
    a_run: assert property (p_run) else $error("no idle");
    property p_sel;
        @(negedge tck_i) disable iff (rst_i)
        (state_o == ST_SEL_DR && tms_i) |=> state_o == ST_SEL_IR;
    endproperty
    a_sel: assert property (p_sel) else $error("no sel ir");
    property p_upd;
        @(negedge tck_i) disable iff (rst_i)
        (state_o == ST_UPD_IR && !tms_i) |=> state_o == ST_IDLE;
    endproperty
    a_upd: assert property (p_upd) else $error("no idle");
    c_sh_ir: cover property (@(negedge tck_i) state_o == ST_SH_IR);
    c_sh_dr: cover property (@(negedge tck_i) state_o == ST_SH_DR);
    c_reset: cover property (@(negedge tck_i) tms_i [*5]);
endmodule : stap_tap_checker

bind stap_tap stap_tap_checker #(.BSR_W(BSR_W)) i_stap_tap_checker (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .ring_i(ring_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .outputs_hiz_o(outputs_hiz_o),
    .state_o(state_o));

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the memory test access port
// Assumes: the controller model owns tck, tms and tdi
// Notes: each test starts from test logic reset
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import stap_pkg::*;
    localparam logic [69:0] RING = {6'h2a, 64'h5c3f_0f1e_9d87_6b4c};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, hiz;
    logic [3:0] state;
    logic [127:0] d;
    int fails = 0;
    int total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    stap_tap i_stap_tap (.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(1'b1),
        .ring_i(RING), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .outputs_hiz_o(hiz), .state_o(state));
    stap_jtag_ctl i_stap_jtag_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic t_power();
        chk(state, ST_RESET);
        chk({tdo_oe, hiz}, 2'b00);
        i_stap_jtag_ctl.step(1'b0, 1'b1, d[0]);
        i_stap_jtag_ctl.scan(1'b0, '1, 32, d);
        chk(d[31:0], STAP_ID_CODE);
        $display("power-up test done");
    endtask : t_power
    // reserved codes must act as bypass
    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            i_stap_jtag_ctl.home();
            chk(state, ST_IDLE);
            i_stap_jtag_ctl.scan(1'b1, codes[i], 3, d);
            chk(d[1:0], 2'b01);
            i_stap_jtag_ctl.scan(1'b0, 128'h1, 2, d);
            chk(d[1:0], 2'b10);
        end
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_boundary();
        logic [2:0] codes [3] = '{3'h4, 3'h0, 3'h2};
        foreach (codes[i]) begin
            i_stap_jtag_ctl.home();
            i_stap_jtag_ctl.scan(1'b1, codes[i], 3, d);
            i_stap_jtag_ctl.scan(1'b0, 128'h1, 71, d);
            chk(d[70:0], {1'b1, RING});
            repeat (20) @(posedge sys_clk);
            chk(hiz, codes[i] != STAP_IR_SAMPLE);
        end
        $display("boundary test done");
    endtask : t_boundary
    task automatic t_idcode();
        i_stap_jtag_ctl.home();
        repeat (20) @(posedge sys_clk);
        chk(hiz, 1'b0);
        i_stap_jtag_ctl.scan(1'b0, 128'h1_2345_6789, 33, d);
        chk(d[32:0], {1'b1, STAP_ID_CODE});
        $display("id test done");
    endtask : t_idcode
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_power();
        t_bypass();
        t_boundary();
        t_idcode();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end
endmodule : tb_top

// ---- pkg/stap_pkg.sv ----
// Purpose: constants and types for the memory test access port
// Assumes: link logic runs on the test clock, system side on sys_clk_i
// Notes: instruction codes are fixed here; boundary length is a parameter
package stap_pkg;

    localparam int STAP_IR_W = 3;
    localparam int STAP_ID_W = 32;
    localparam int STAP_BSR_W = 70;
    localparam logic [STAP_IR_W-1:0] STAP_IR_EXTEST = 3'h0;
    localparam logic [STAP_IR_W-1:0] STAP_IR_IDCODE = 3'h1;
    localparam logic [STAP_IR_W-1:0] STAP_IR_SAMPLEZ = 3'h2;
    localparam logic [STAP_IR_W-1:0] STAP_IR_SAMPLE = 3'h4;
    localparam logic [STAP_IR_W-1:0] STAP_IR_BYPASS = 3'h7;
    localparam logic [1:0] STAP_IR_CAPTURE = 2'h1;
    // identity code value is arbitrary
    localparam logic [STAP_ID_W-1:0] STAP_ID_CODE = 32'h0a5a_5001;
    localparam int STAP_RESET_TMS_EDGES = 5;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } stap_state_type;

    // serial pins as seen by the port
    typedef struct packed {
        logic tms;
        logic tdi;
    } stap_pins_type;

    // serial output pin pair
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } stap_tdo_type;

endpackage : stap_pkg

// ---- rtl/stap_shreg.sv ----
// Purpose: capture/shift register for one scan path
// Assumes: clocked by the test clock, reset asynchronously
// Notes: shifts toward bit 0; serial in enters the top bit
module stap_shreg #(
    parameter int WIDTH = 32
) (
    input wire logic tck_i,              // test clock
    input wire logic rst_i,              // async reset, active high
    input wire logic cap_i,              // load parallel value
    input wire logic shift_i,            // shift one place
    input wire logic sin_i,              // serial in
    input wire logic [WIDTH-1:0] par_i,  // parallel capture value
    output logic sout_o                  // lowest bit
);
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] shifted;

    if (WIDTH < 1) begin : g_bad_width
        $error("stap_shreg: WIDTH must be at least 1");
    end

    // a one-cell register just takes the serial bit; the wide form would
    // name a reversed slice, so it is only built where it exists
    if (WIDTH == 1) begin : g_one
        assign shifted = sin_i;
    end else begin : g_many
        assign shifted = {sin_i, data_q[WIDTH-1:1]};
    end

    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            data_q <= '0;
        end else if (cap_i) begin
            data_q <= par_i;
        end else if (shift_i) begin
            data_q <= shifted;
        end
    end

    assign sout_o = data_q[0];

endmodule : stap_shreg

// ---- rtl/stap_tap.sv ----
// Purpose: test access port of a burst memory, controller on the test clock
// Assumes: system clock samples the memory pin ring for capture and the hiz request
// Notes: the output float request is the only path back into memory operation
module stap_tap
    import stap_pkg::*;
#(
    parameter int BSR_W = STAP_BSR_W
) (
    input wire logic sys_clk_i,              // memory clock
    input wire logic rst_i,                  // power-up reset, async high
    input wire logic clk_en_i,               // system side clock enable
    input wire logic [BSR_W-1:0] ring_i,     // memory pin ring, sys domain
    input wire logic tck_i,                  // test clock
    input wire logic tms_i,                  // mode select (pull-up outside)
    input wire logic tdi_i,                  // serial data in
    output logic tdo_o,                      // serial data out
    output logic tdo_oe_o,                   // high while driving tdo
    output logic outputs_hiz_o,              // float memory outputs
    output logic [3:0] state_o               // controller state
);
    // width of the consecutive high mode select counter
    localparam int CNT_W = $clog2(STAP_RESET_TMS_EDGES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STAP_RESET_TMS_EDGES - 1);

    typedef struct packed {
        stap_state_type st;
        logic [STAP_IR_W-1:0] ir_sh;
        logic [STAP_IR_W-1:0] ir;
        logic hiz;
        logic [CNT_W-1:0] tms_cnt;
    } stap_tck_type;

    typedef struct packed {
        logic [BSR_W-1:0] ring;
    } stap_sys_type;

    typedef struct packed {
        stap_tdo_type pin;
        logic [3:0] st;
    } stap_neg_type;

    stap_tck_type r_q, r_d;
    stap_sys_type s_q, s_d;
    stap_neg_type n_q, n_d;
    stap_pins_type pins;
    logic [BSR_W-1:0] ring_sync1_q, ring_sync2_q;
    logic bsr_out, id_out, byp_out;
    logic cap_dr, sh_dr, do_bsr, do_id, do_byp;

    // the ring register must be wider than the one-cell bypass path
    if (BSR_W < 2) begin : g_bad_bsr
        $error("stap_tap: BSR_W must be at least 2");
    end

    // pins come from the tck domain itself, sampled at rising edges
    // an open pin reads high through the pad pull-ups ahead of this port
    assign pins = '{tms: tms_i, tdi: tdi_i};

    // system side snapshot of the memory pin ring; clock enable freezes it
    always_comb begin
        s_d = s_q;
        if (clk_en_i) begin
            s_d.ring = ring_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ring is sampled into tck domain by two flops; capture may see a
    // transition, which the port tolerates as an unreliable bit
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            ring_sync1_q <= '0;
            ring_sync2_q <= '0;
        end else begin
            ring_sync1_q <= s_q.ring;
            ring_sync2_q <= ring_sync1_q;
        end
    end

    function automatic stap_state_type next_st(stap_state_type s,
                                                logic m);
        unique case (s)
            ST_RESET: next_st = m ? ST_RESET : ST_IDLE;
            ST_IDLE: next_st = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_st = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_st = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_st = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_st = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_st = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_st = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_st = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_st = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_st = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_st = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_st = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_st = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_st = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_st = m ? ST_SEL_DR : ST_IDLE;
        endcase
    endfunction : next_st

    // states in which the serial output is driven
    function automatic logic is_shift(stap_state_type s);
        is_shift = (s == ST_SH_DR) || (s == ST_SH_IR);
    endfunction : is_shift

    // instructions that route the pin ring register
    function automatic logic picks_bsr(logic [STAP_IR_W-1:0] c);
        picks_bsr = (c == STAP_IR_EXTEST) || (c == STAP_IR_SAMPLEZ)
                 || (c == STAP_IR_SAMPLE);
    endfunction : picks_bsr

    // instructions that float the memory outputs
    function automatic logic floats_mem(logic [STAP_IR_W-1:0] c);
        floats_mem = (c == STAP_IR_EXTEST) || (c == STAP_IR_SAMPLEZ);
    endfunction : floats_mem

    // data register selection; reserved codes fall to bypass so chains
    // with compliant ports keep a known length
    always_comb begin
        do_bsr = picks_bsr(r_q.ir);
        do_id = (r_q.ir == STAP_IR_IDCODE);
        do_byp = !do_bsr && !do_id;
    end

    assign cap_dr = (r_q.st == ST_CAP_DR);
    assign sh_dr = (r_q.st == ST_SH_DR);

    stap_shreg #(.WIDTH(BSR_W)) u_bsr (
        .tck_i(tck_i),
        .rst_i(rst_i),
        .cap_i(cap_dr && do_bsr),
        .shift_i(sh_dr && do_bsr),
        .sin_i(pins.tdi),
        .par_i(ring_sync2_q),
        .sout_o(bsr_out)
    );

    stap_shreg #(.WIDTH(STAP_ID_W)) u_id (
        .tck_i(tck_i),
        .rst_i(rst_i),
        .cap_i(cap_dr && do_id),
        .shift_i(sh_dr && do_id),
        .sin_i(pins.tdi),
        .par_i(STAP_ID_CODE),
        .sout_o(id_out)
    );

    // bypass captures low, as the bypass register is cleared on capture
    stap_shreg #(.WIDTH(1)) u_byp (
        .tck_i(tck_i),
        .rst_i(rst_i),
        .cap_i(cap_dr && do_byp),
        .shift_i(sh_dr && do_byp),
        .sin_i(pins.tdi),
        .par_i(1'b0),
        .sout_o(byp_out)
    );

    // controller, instruction path and output float control
    always_comb begin
        r_d = r_q;
        r_d.st = next_st(r_q.st, pins.tms);
        unique case (r_q.st)
            ST_RESET: begin
                r_d.ir = STAP_IR_IDCODE;
                r_d.hiz = 1'b0;
            end
            ST_CAP_IR: begin
                r_d.ir_sh = {1'b0, STAP_IR_CAPTURE};
            end
            ST_SH_IR: begin
                r_d.ir_sh = {pins.tdi, r_q.ir_sh[STAP_IR_W-1:1]};
            end
            ST_UPD_IR: begin
                r_d.ir = r_q.ir_sh;
                r_d.hiz = floats_mem(r_q.ir_sh);
            end
            default: begin
            end
        endcase
        // saturating count of high mode select edges backs up the table,
        // so even a corrupted state code homes within five edges
        if (!pins.tms) begin
            r_d.tms_cnt = '0;
        end else if (r_q.tms_cnt < CNT_LAST) begin
            r_d.tms_cnt = r_q.tms_cnt + CNT_W'(1);
        end else begin
            r_d.st = ST_RESET;
        end
    end

    // five high tms edges reach reset from any state through the table;
    // power-up reset lands here too, without touching memory use
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '{st: ST_RESET,
                     ir_sh: '0,
                     ir: STAP_IR_IDCODE,
                     hiz: 1'b0,
                     tms_cnt: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // falling edge output stage
    always_comb begin
        n_d = n_q;
        n_d.st = r_q.st;
        n_d.pin.tdo_oe = is_shift(r_q.st);
        if (r_q.st == ST_SH_IR) begin
            n_d.pin.tdo = r_q.ir_sh[0];
        end else if (do_bsr) begin
            n_d.pin.tdo = bsr_out;
        end else if (do_id) begin
            n_d.pin.tdo = id_out;
        end else begin
            n_d.pin.tdo = byp_out;
        end
    end

    always_ff @(negedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            n_q <= '{pin: '{tdo: 1'b0, tdo_oe: 1'b0}, st: 4'h0};
        end else begin
            n_q <= n_d;
        end
    end

    // hiz request is a tck flop, read only as a level through two system
    // flops; the clock enable freezes them with the rest of system state
    typedef struct packed {
        logic meta;
        logic level;
    } stap_hiz_type;

    stap_hiz_type h_q, h_d;

    always_comb begin
        h_d = h_q;
        if (clk_en_i) begin
            h_d.meta = r_q.hiz;
            h_d.level = h_q.meta;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    assign tdo_o = n_q.pin.tdo;
    assign tdo_oe_o = n_q.pin.tdo_oe;
    assign state_o = n_q.st;
    assign outputs_hiz_o = h_q.level;

endmodule : stap_tap
